//--- dv/lfc_ctrl_checker.sv
// lfc_ctrl_checker: port assertions of the frame rate and contrast block
// assumes it is bound to lfc_ctrl and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module lfc_ctrl_checker
    import lfc_pkg::*;
#(
    parameter int unsigned DRV_C0 = 1, DRV_C1 = 1, DRV_C2 = 1, DRV_C3 = 1,
    parameter int unsigned DRV_C4 = 1, DRV_C5 = 1, DRV_C6 = 1
)
(
    input  wire logic       CLK_I,         // system clock
    input  wire logic       SRST_I,        // sync reset
    input  wire logic [1:0] ADDR_I,        // register index
    input  wire logic [7:0] WDATA_I,       // write data
    input  wire logic       WR_I,          // write strobe
    input  wire logic       RD_I,          // read strobe
    input  wire logic [7:0] RDATA_O,       // read data
    input  wire logic       ASYNC_CLK_I,   // async source clock
    input  wire logic       PS_CLK_O,      // prescaled clock
    input  wire logic       FRAME_START_O, // frame start pulse
    input  wire logic       DRIVE_ON_O,    // drivers conducting
    input  wire logic [3:0] CONTRAST_O     // applied contrast code
);
    logic [3:0] lvl_r;                     // last written contrast_level

    ////////////////////////////////////////////////////////////////////////
    // mirror of the pending contrast code
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lvl_r <= 4'h0;
        end else if (WR_I && ADDR_I == ADDR_CONTRAST) begin
            lvl_r <= WDATA_I[3:0];
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    ////////////////////////////////////////////////////////////////////////
    // frame pulse steps
    sequence quiet_frame;
        !FRAME_START_O [*8];
    endsequence
    sequence applied_level;
        CONTRAST_O == $past(lvl_r);
    endsequence

    rdata_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data not zero outside a read");
    fr_resv_a: assert property (
        RD_I && ADDR_I == ADDR_FRAME_RATE |=> !RDATA_O[7] && !RDATA_O[3])
        else $error("frame rate reserved bits not zero");
    cc_resv_a: assert property (
        RD_I && ADDR_I == ADDR_CONTRAST |=> !RDATA_O[4])
        else $error("contrast reserved bit not zero");
    unmapped_rd_a: assert property (RD_I && ADDR_I == 2'h3 |=> RDATA_O == 0)
        else $error("unmapped read not zero");
    fs_spacing_a: assert property (FRAME_START_O |=> quiet_frame)
        else $error("frame start pulses too close");
    contrast_hold_a: assert property (
        $changed(CONTRAST_O) |-> $past(FRAME_START_O))
        else $error("contrast changed outside frame start");
    contrast_apply_a: assert property (
        FRAME_START_O |=> applied_level)
        else $error("contrast not taken at frame start");
    drive_rise_a: assert property ($changed(PS_CLK_O) |=> DRIVE_ON_O)
        else $error("drivers off at a clock transition");
endmodule : lfc_ctrl_checker
`default_nettype wire

bind lfc_ctrl lfc_ctrl_checker #(
    .DRV_C0(DRV_C0), .DRV_C1(DRV_C1), .DRV_C2(DRV_C2), .DRV_C3(DRV_C3),
    .DRV_C4(DRV_C4), .DRV_C5(DRV_C5), .DRV_C6(DRV_C6)
) chk_i (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ASYNC_CLK_I(ASYNC_CLK_I),
    .PS_CLK_O(PS_CLK_O), .FRAME_START_O(FRAME_START_O),
    .DRIVE_ON_O(DRIVE_ON_O), .CONTRAST_O(CONTRAST_O)
);

//--- dv/lfc_ctrl_tb.sv
// lfc_ctrl_tb: self-checking bench of the frame rate and contrast block
// assumes short drive-time parameters and a 40 ns async source clock
`timescale 1ns/1ns
`default_nettype none
module lfc_ctrl_tb;
    import lfc_pkg::*;
    localparam int DRV [8] = '{6, 2, 3, 8, 10, 12, 14, 0};
    localparam logic [7:0] FR_T [6] = '{8'h00, 8'h01, 8'h07, 8'h10, 8'h13,
                                         8'h30};
    localparam logic [7:0] CT_T [6] = '{8'h30, 8'h30, 8'h20, 8'h10, 8'h00,
                                         8'h20};
    localparam logic [7:0] DC_T [8] = '{8'h20, 8'h40, 8'hC0, 8'hE0, 8'h20,
                                         8'h20, 8'h00, 8'h80};
    localparam logic [7:0] DM_T [8] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h00,
                                         8'h31, 8'h30, 8'h30};
    logic        clk, srst, wr, rd, aclk;
    logic [1:0]  addr;
    logic [7:0]  wdata, rdata;
    logic        ps_clk, fs, drv_on;
    logic [3:0]  contrast;
    logic [15:0] gap;
    int          mismatches, comparisons;

    ////////////////////////////////////////////////////////////////////////
    // design and glass stand-in
    lfc_ctrl #(.DRV_C0(DRV[0]), .DRV_C1(DRV[1]), .DRV_C2(DRV[2]),
               .DRV_C3(DRV[3]), .DRV_C4(DRV[4]), .DRV_C5(DRV[5]),
               .DRV_C6(DRV[6])) DUT (
        .CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ASYNC_CLK_I(aclk),
        .PS_CLK_O(ps_clk), .FRAME_START_O(fs), .DRIVE_ON_O(drv_on),
        .CONTRAST_O(contrast));
    lfc_glass_model glass (.clk_i(clk), .srst_i(srst), .frame_i(fs),
                           .gap_o(gap));

    // system clock and unrelated slow source clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        aclk = 1'b0;
        #3;
        forever #20 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus cycles and comparison
    task automatic chk(input string nm, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("read data", {24'h0, exp}, {24'h0, rdata});
    endtask : rd_chk
    task automatic wait_fs;
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (fs !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 3000) chk("frame start seen", 1, 0);
    endtask : wait_fs
    // frame length from tap, divide and duty codes
    function automatic logic [31:0] k_n_d(logic [7:0] fr, logic [7:0] ct);
        int k, n;
        k = (ct[5:4] == 2'b10) ? 6 : 8;
        n = (fr[6:4] == 3'h0) ? 16 : (32 << fr[6:4]);
        return k * n * (fr[2:0] + 1);
    endfunction : k_n_d

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        rd_chk(0, 8'h00); rd_chk(1, 8'h00); rd_chk(2, 8'h00);
        wr_reg(0, 8'hFF); rd_chk(0, 8'h77);
        wr_reg(1, 8'hFF); rd_chk(1, 8'hEF);
        wr_reg(2, 8'hFF); rd_chk(2, 8'hB1);
        wr_reg(3, 8'h5A); rd_chk(3, 8'h00);
        rd_chk(0, 8'h77);
        wr_reg(0, 8'h00); wr_reg(1, 8'h20); wr_reg(2, 8'h30);
        $display("test regs done");
    endtask : t_regs
    task automatic t_frames;
        for (int i = 0; i < 6; i++) begin
            wr_reg(0, FR_T[i]); wr_reg(2, CT_T[i]);
            wait_fs; wait_fs;
            // glass latches the gap one edge after the pulse is seen
            @(posedge clk);
            #1 chk("frame gap", k_n_d(FR_T[i], CT_T[i]), {16'h0, gap});
        end
        wr_reg(0, 8'h00); wr_reg(2, 8'hB0);
        wait_fs; wait_fs;
        @(posedge clk);
        #1 chk("async gap", 4 * k_n_d(8'h00, 8'h30), {16'h0, gap});
        wr_reg(2, 8'h30);
        $display("test frames done");
    endtask : t_frames
    task automatic t_contrast;
        logic [3:0] prev;
        wait_fs;
        @(posedge clk);
        prev = 4'h0;
        for (int v = 15; v >= 0; v--) begin
            wr_reg(1, {4'h2, 4'(v)});
            #1 chk("contrast held", {28'h0, prev}, {28'h0, contrast});
            wait_fs;
            @(posedge clk);
            #1 chk("contrast taken", v, {28'h0, contrast});
            prev = 4'(v);
        end
        $display("test contrast done");
    endtask : t_contrast
    task automatic t_drive;
        int c, e, t;
        logic p;
        for (int i = 0; i < 8; i++) begin
            wr_reg(1, DC_T[i]); wr_reg(2, DM_T[i]);
            e = DRV[DC_T[i][7:5]] >= 8 ? 64 : DRV[DC_T[i][7:5]] * 8;
            if (DC_T[i][7:5] == 3'h7) e = 64;
            if (DM_T[i][5:4] == 2'b00 || DM_T[i][0]) e = 64;
            repeat (32) @(posedge clk);
            #1 c = 0;
            t = 0;
            p = ps_clk;
            repeat (64) begin
                @(posedge clk);
                #1 c += (drv_on === 1'b1);
                t += (ps_clk !== p);
                p = ps_clk;
            end
            chk("drive cycles", e, c);
            chk("clock toggles", 8, t);
        end
        $display("test drive done");
    endtask : t_drive

    ////////////////////////////////////////////////////////////////////////
    // verdict and run
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #400000;
        mismatches++;
        end_of_test;
    end
    initial begin
        srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 2'h0; wdata = 8'h00;
        mismatches = 0; comparisons = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1 chk("reset contrast", 0, {28'h0, contrast});
        t_regs;
        t_frames;
        t_contrast;
        t_drive;
        end_of_test;
    end
endmodule : lfc_ctrl_tb
`default_nettype wire

//--- dv/lfc_glass_model.sv
// lfc_glass_model: panel glass stand-in that times each frame
// assumes it sees the block outputs on the system clock
`timescale 1ns/1ns
`default_nettype none
module lfc_glass_model (
    input  wire logic        clk_i,   // system clock
    input  wire logic        srst_i,  // sync reset
    input  wire logic        frame_i, // frame start pulse
    output logic      [15:0] gap_o    // cycles of last frame
);
    logic [15:0] cnt_r;               // cycles since last frame start

    ////////////////////////////////////////////////////////////////////////
    // cycle count restarted by every frame start pulse
    always_ff @(posedge clk_i) begin
        if (srst_i || frame_i) begin
            cnt_r <= 16'h0001;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // length of the frame just ended
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gap_o <= 16'h0000;
        end else if (frame_i) begin
            gap_o <= cnt_r;
        end
    end
endmodule : lfc_glass_model
`default_nettype wire

//--- hw/lfc_ctrl.sv
// lfc_ctrl: frame rate, driver on-time and contrast control of a segment
// panel controller, with its three byte registers
// assumes a single-cycle register port on CLK_I; ASYNC_CLK_I is unrelated
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (R1) Bits 6:4 of frame_rate_setup pick prescaler N of 16,64,...,4096.
// (R2) Bits 2:0 of frame_rate_setup divide the prescaler output by field+1.
// (R3) Prescaler then divider form the prescaled clock timing the block.
// (R4) A frame lasts K*N*D source clocks, K being 6 at 1/3 duty, else 8.
// (R5) Bits 7 and 3 of frame_rate_setup read as zero.
// (R6) Bits 7:5 of contrast_drive_setup pick a nominal driver on-time.
// (R7) Driver on-time never exceeds half a prescaled clock period.
// (R8) Static duty or blanking forces half a period of on-time.
// (R9) Bits 3:0 of contrast_drive_setup choose the voltage generator code.
// (R10) A new contrast code reaches the generator only at frame start.
// (R11) Bit 4 of contrast_drive_setup reads as zero.
// (R12) Duty codes are 00 static, 01 half, 10 third, 11 quarter.
// (R13) The source clock is CLK_I when the source bit is 0, else ASYNC_CLK_I.
// (R14) A one-cycle frame start pulse ends each K prescaled periods.
module lfc_ctrl
    import lfc_pkg::*;
#(
    parameter int unsigned DRV_C0 = DRV_T0_NS / CLK_PERIOD_NS, // 300 us
    parameter int unsigned DRV_C1 = DRV_T1_NS / CLK_PERIOD_NS, // 70 us
    parameter int unsigned DRV_C2 = DRV_T2_NS / CLK_PERIOD_NS, // 150 us
    parameter int unsigned DRV_C3 = DRV_T3_NS / CLK_PERIOD_NS, // 450 us
    parameter int unsigned DRV_C4 = DRV_T4_NS / CLK_PERIOD_NS, // 575 us
    parameter int unsigned DRV_C5 = DRV_T5_NS / CLK_PERIOD_NS, // 850 us
    parameter int unsigned DRV_C6 = DRV_T6_NS / CLK_PERIOD_NS  // 1150 us
)
(
    input  wire logic       CLK_I,         // system clock, 100 MHz
    input  wire logic       SRST_I,        // sync reset, active high
    input  wire logic [1:0] ADDR_I,        // register index
    input  wire logic [7:0] WDATA_I,       // write data
    input  wire logic       WR_I,          // write strobe
    input  wire logic       RD_I,          // read strobe
    output logic      [7:0] RDATA_O,       // read data, cycle after RD_I
    input  wire logic       ASYNC_CLK_I,   // asynchronous source clock
    output logic            PS_CLK_O,      // prescaled_panel_clock level
    output logic            FRAME_START_O, // frame start pulse
    output logic            DRIVE_ON_O,    // panel drivers conducting
    output logic      [3:0] CONTRAST_O     // code to voltage generator
);

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [2:0] prescale_tap_sel_r;
    logic [2:0] frame_divide_sel_r;
    logic [2:0] drive_time_sel_r;
    logic [3:0] contrast_level_r;
    logic       panel_clock_source_r;
    lfc_duty_t  duty_sel_r;
    logic       blank_display_r;
    logic [7:0] rdata_r;

    // async source synchroniser and edge detect
    logic       async_s1_r;
    logic       async_s2_r;
    logic       async_s3_r;
    logic       async_rise;

    // frame sequencer
    logic [2:0] fcnt_r;
    logic [2:0] k_last;
    logic       frame_start_r;

    // contrast applied to the generator
    logic [3:0] contrast_applied_r;

    // driver on-time
    logic                 drive_r;
    logic [DRV_CNT_W-1:0] drv_cnt_r;
    logic [DRV_CNT_W-1:0] drv_limit;
    logic                 drv_half_mode;

    lfc_tick_if tk ();

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            prescale_tap_sel_r <= FRAME_RATE_RST[TAP_LSB +: 3];
            frame_divide_sel_r <= FRAME_RATE_RST[DIV_LSB +: 3];
        end else if (WR_I && (ADDR_I == ADDR_FRAME_RATE)) begin
            prescale_tap_sel_r <= WDATA_I[TAP_LSB +: 3]; // R1
            frame_divide_sel_r <= WDATA_I[DIV_LSB +: 3]; // R2
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            drive_time_sel_r <= CONTRAST_RST[DRV_LSB +: 3];
            contrast_level_r <= CONTRAST_RST[LVL_LSB +: 4];
        end else if (WR_I && (ADDR_I == ADDR_CONTRAST)) begin
            drive_time_sel_r <= WDATA_I[DRV_LSB +: 3]; // R6
            contrast_level_r <= WDATA_I[LVL_LSB +: 4]; // R9
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            panel_clock_source_r <= PANEL_CTRL_RST[SRC_BIT];
            duty_sel_r           <= lfc_duty_t'(PANEL_CTRL_RST[DUTY_LSB +: 2]);
            blank_display_r      <= PANEL_CTRL_RST[BLANK_BIT];
        end else if (WR_I && (ADDR_I == ADDR_PANEL_CTRL)) begin
            panel_clock_source_r <= WDATA_I[SRC_BIT];
            duty_sel_r           <= lfc_duty_t'(WDATA_I[DUTY_LSB +: 2]); // R12
            blank_display_r      <= WDATA_I[BLANK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, data valid only in the cycle after the strobe
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rdata_r <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                ADDR_FRAME_RATE: begin
                    rdata_r <= {1'b0, prescale_tap_sel_r,
                                1'b0, frame_divide_sel_r}; // R5
                end
                ADDR_CONTRAST: begin
                    rdata_r <= {drive_time_sel_r, 1'b0,
                                contrast_level_r}; // R11
                end
                ADDR_PANEL_CTRL: begin
                    rdata_r <= {panel_clock_source_r, 1'b0, duty_sel_r,
                                3'h0, blank_display_r};
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign RDATA_O = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // asynchronous source clock: two-flop sync, then edge detect
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            async_s1_r <= 1'b0;
            async_s2_r <= 1'b0;
            async_s3_r <= 1'b0;
        end else begin
            async_s1_r <= ASYNC_CLK_I;
            async_s2_r <= async_s1_r;
            async_s3_r <= async_s2_r;
        end
    end

    assign async_rise = async_s2_r && !async_s3_r;

    ////////////////////////////////////////////////////////////////////////
    // source clock select and prescaler/divider
    assign tk.src_tick = panel_clock_source_r ? async_rise : 1'b1; // R13
    assign tk.tap_sel  = prescale_tap_sel_r;
    assign tk.div_sel  = frame_divide_sel_r;

    lfc_presc u_presc (
        .clk_i  (CLK_I),
        .srst_i (SRST_I),
        .tk     (tk.presc)
    );

    assign PS_CLK_O = tk.ps_level; // R3

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer: K prescaled periods per frame
    always_comb begin
        k_last = (duty_sel_r == LFC_DUTY_THIRD) ? K_THIRD_LAST
                                                : K_OTHER_LAST; // R4
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            fcnt_r        <= 3'h0;
            frame_start_r <= 1'b0;
        end else if (tk.full_tick) begin
            if (fcnt_r >= k_last) begin
                fcnt_r        <= 3'h0;
                frame_start_r <= 1'b1; // R14
            end else begin
                fcnt_r        <= fcnt_r + 3'h1; // R4
                frame_start_r <= 1'b0;
            end
        end else begin
            frame_start_r <= 1'b0;
        end
    end

    assign FRAME_START_O = frame_start_r;

    ////////////////////////////////////////////////////////////////////////
    // contrast code taken over only at frame start
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            contrast_applied_r <= CONTRAST_RST[LVL_LSB +: 4];
        end else if (frame_start_r) begin
            contrast_applied_r <= contrast_level_r; // R10
        end
    end

    assign CONTRAST_O = contrast_applied_r; // R9

    ////////////////////////////////////////////////////////////////////////
    // nominal on-time in system cycles
    always_comb begin
        unique case (drive_time_sel_r)
            3'h0:    drv_limit = DRV_CNT_W'(DRV_C0); // R6
            3'h1:    drv_limit = DRV_CNT_W'(DRV_C1);
            3'h2:    drv_limit = DRV_CNT_W'(DRV_C2);
            3'h3:    drv_limit = DRV_CNT_W'(DRV_C3);
            3'h4:    drv_limit = DRV_CNT_W'(DRV_C4);
            3'h5:    drv_limit = DRV_CNT_W'(DRV_C5);
            3'h6:    drv_limit = DRV_CNT_W'(DRV_C6);
            default: drv_limit = DRV_CNT_W'(DRV_C6);
        endcase
        // half-period mode: stay on until the next transition
        drv_half_mode = (drive_time_sel_r == DRV_HALF_CODE)
                     || (duty_sel_r == LFC_DUTY_STATIC)
                     || blank_display_r; // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // driver on-time: starts at each transition, ends at the nominal time
    // or at the next transition, whichever comes first
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            drive_r   <= 1'b0;
            drv_cnt_r <= '0;
        end else if (tk.half_tick) begin
            drive_r   <= 1'b1; // R7
            drv_cnt_r <= DRV_CNT_W'(1);
        end else if (drive_r && !drv_half_mode) begin
            if (drv_cnt_r >= drv_limit) begin
                drive_r <= 1'b0; // R6
            end else begin
                drv_cnt_r <= drv_cnt_r + 1'b1;
            end
        end
    end

    assign DRIVE_ON_O = drive_r;

endmodule : lfc_ctrl
`default_nettype wire

//--- hw/lfc_presc.sv
// lfc_presc: tap prescaler plus 1..8 divider making the prescaled clock
// assumes src_tick marks one panel source clock edge per system cycle
`timescale 1ns/1ns
`default_nettype none
module lfc_presc
    import lfc_pkg::*;
(
    input  wire logic     clk_i,  // system clock
    input  wire logic     srst_i, // synchronous reset
    lfc_tick_if.presc     tk      // settings in, ticks out
);

    logic [PRESC_W-1:0] pcnt_r;      // free running source count
    logic [PRESC_W-1:0] half_mask;   // low bits for N/2
    logic               pre_tick;    // one tick per N/2 source edges
    logic [DCNT_W-1:0]  dcnt_r;      // half periods inside divider
    logic [DCNT_W-1:0]  d_last;      // D - 1
    logic [DCNT_W-1:0]  d2_last;     // 2D - 1
    logic               mid_hit;
    logic               end_hit;

    ////////////////////////////////////////////////////////////////////////
    // tap select: mask of log2(N)-1 low bits
    always_comb begin
        half_mask = PRESC_W'((1 << (TAP_LOG2[tk.tap_sel] - 1)) - 1); // R1
        pre_tick  = tk.src_tick && ((pcnt_r & half_mask) == half_mask);
    end

    // source edge counter
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pcnt_r <= '0;
        end else if (tk.src_tick) begin
            pcnt_r <= pcnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider: D = field + 1, counted in half periods
    always_comb begin
        d_last  = DCNT_W'(tk.div_sel);                      // R2
        d2_last = DCNT_W'({tk.div_sel, 1'b1});              // R2
        mid_hit = (dcnt_r == d_last);
        end_hit = (dcnt_r >= d2_last);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dcnt_r <= '0;
        end else if (pre_tick) begin
            dcnt_r <= end_hit ? '0 : dcnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaled clock level and registered tick pulses
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tk.half_tick <= 1'b0;
            tk.full_tick <= 1'b0;
            tk.ps_level  <= 1'b0;
        end else begin
            tk.half_tick <= pre_tick && (mid_hit || end_hit); // R3
            tk.full_tick <= pre_tick && end_hit;              // R3
            if (pre_tick && (mid_hit || end_hit)) begin
                tk.ps_level <= ~tk.ps_level;
            end
        end
    end

endmodule : lfc_presc
`default_nettype wire

//--- pkg/lfc_pkg.sv
// lfc_pkg: constants and types of the panel frame rate and contrast block
// assumes a 100 MHz system clock and byte-wide register port
package lfc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock
    localparam int unsigned CLK_PERIOD_NS = 10;

    ////////////////////////////////////////////////////////////////////////
    // register indices on the plain port
    localparam logic [1:0] ADDR_FRAME_RATE  = 2'h0; // frame_rate_setup
    localparam logic [1:0] ADDR_CONTRAST    = 2'h1; // contrast_drive_setup
    localparam logic [1:0] ADDR_PANEL_CTRL  = 2'h2; // panel control bits

    // reset values
    localparam logic [7:0] FRAME_RATE_RST   = 8'h00;
    localparam logic [7:0] CONTRAST_RST     = 8'h00;
    localparam logic [7:0] PANEL_CTRL_RST   = 8'h00;

    // frame_rate_setup fields
    localparam int unsigned TAP_LSB         = 4;    // prescale_tap_sel 6:4
    localparam int unsigned DIV_LSB         = 0;    // frame_divide_sel 2:0
    // contrast_drive_setup fields
    localparam int unsigned DRV_LSB         = 5;    // drive_time_sel 7:5
    localparam int unsigned LVL_LSB         = 0;    // contrast_level 3:0
    // panel control fields
    localparam int unsigned SRC_BIT         = 7;    // panel_clock_source
    localparam int unsigned DUTY_LSB        = 4;    // duty_sel 5:4
    localparam int unsigned BLANK_BIT       = 0;    // blank_display

    ////////////////////////////////////////////////////////////////////////
    // duty encodings and frame factor K
    typedef enum logic [1:0] {
        LFC_DUTY_STATIC,
        LFC_DUTY_HALF,
        LFC_DUTY_THIRD,
        LFC_DUTY_QUARTER
    } lfc_duty_t;

    localparam logic [2:0] K_THIRD_LAST     = 3'h5; // K = 6, counts 0..5
    localparam logic [2:0] K_OTHER_LAST     = 3'h7; // K = 8, counts 0..7

    // log2 of prescaler division N, per tap code 0..7
    localparam int unsigned TAP_LOG2 [8] = '{4, 6, 7, 8, 9, 10, 11, 12};
    localparam int unsigned PRESC_W         = 12;   // N up to 4096
    localparam int unsigned DCNT_W          = 4;    // half periods up to 2*8

    ////////////////////////////////////////////////////////////////////////
    // nominal driver on-times, codes 0..6; code 7 is half a period
    localparam int unsigned DRV_T0_NS       = 300000;
    localparam int unsigned DRV_T1_NS       = 70000;
    localparam int unsigned DRV_T2_NS       = 150000;
    localparam int unsigned DRV_T3_NS       = 450000;
    localparam int unsigned DRV_T4_NS       = 575000;
    localparam int unsigned DRV_T5_NS       = 850000;
    localparam int unsigned DRV_T6_NS       = 1150000;
    localparam logic [2:0]  DRV_HALF_CODE   = 3'h7;
    localparam int unsigned DRV_CNT_W       = 17;   // 115000 cycles fits

endpackage : lfc_pkg

//--- pkg/lfc_tick_if.sv
// lfc_tick_if: settings to and ticks from the prescaler/divider
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface lfc_tick_if;
    logic       src_tick;   // one panel source clock edge
    logic [2:0] tap_sel;    // prescale_tap_sel
    logic [2:0] div_sel;    // frame_divide_sel
    logic       half_tick;  // each transition of prescaled clock
    logic       full_tick;  // each full prescaled clock period
    logic       ps_level;   // prescaled_panel_clock level

    modport presc (
        input  src_tick, tap_sel, div_sel,
        output half_tick, full_tick, ps_level
    );
    modport core (
        output src_tick, tap_sel, div_sel,
        input  half_tick, full_tick, ps_level
    );
endinterface : lfc_tick_if
`default_nettype wire
